// File: hdl/ot_resp_pkg.sv
// Constants shared by the overtemperature supervisor and its limit decoder.
// Assumes a 10 MHz system clock and temperatures in whole degrees Celsius.
package ot_resp_pkg;

    // Command codes of the two configuration registers
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h50;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;

    // Fault action register fields
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;

    // Warning threshold register fields (linear format)
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int MAN_LSB = 0;

    // Reset values; exponent resets to zero, mantissa value is a plain default
    localparam logic [7:0] FAULT_ACTION_RST = 8'h80;
    localparam logic [15:0] WARN_LIMIT_RST = 16'h0064;

    // Temperature figures in degrees Celsius
    localparam logic signed [15:0] DISABLE_DEGC = 16'sh00ff;
    localparam logic signed [15:0] HYST_DEGC = 16'sh0014;
    localparam logic signed [15:0] STORE_MIN_DEGC = 16'sh0000;
    localparam logic signed [15:0] STORE_MAX_DEGC = 16'sh00a0;

    // Retry field codes
    localparam logic [2:0] RETRY_LATCH = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Shutdown delay for delay code zero, in ms
    localparam logic [15:0] DELAY0_MS = 16'h000a;

    // Timing: clock period and the millisecond tick derived from it
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACT_IGNORE,
        ACT_DELAYED,
        ACT_IMMEDIATE,
        ACT_HOLD
    } action_t;

endpackage : ot_resp_pkg

// File: hdl/lin11_to_degc.sv
// Converts a linear-format temperature word into whole degrees, rounded.
// Assumes the word comes from a register on the same clock; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module lin11_to_degc (
    input wire logic [15:0] word,
    output logic signed [15:0] degc,
    output logic in_range
);
    import ot_resp_pkg::*;

    always_comb begin
        logic signed [31:0] man;
        logic signed [31:0] val;
        logic signed [5:0] ex;
        logic [4:0] sh;
        man = 32'(signed'(word[MAN_MSB:MAN_LSB]));
        ex = 6'(signed'(word[EXP_MSB:EXP_LSB]));
        sh = 5'(-ex);
        val = '0;
        if (!ex[5]) begin
            // Large exponents saturate; nothing that big is a supported option
            if (ex > 6'sd8) begin
                val = man[31] ? -32'sd65536 : 32'sd65536;
            end else begin
                val = man <<< ex[3:0];
            end
        end else begin
            // Round to the nearest whole degree
            val = (man + (32'sd1 <<< 5'(sh - 5'h01))) >>> sh;
        end
        if (val > 32'sd32767) begin
            degc = 16'sh7fff;
        end else if (val < -32'sd32768) begin
            degc = 16'sh8000;
        end else begin
            degc = val[15:0];
        end
        in_range = ((degc >= STORE_MIN_DEGC) && (degc <= STORE_MAX_DEGC))
            || (degc == DISABLE_DEGC);
    end

endmodule : lin11_to_degc
`default_nettype wire

// File: hdl/ot_supervisor.sv
// Overtemperature supervisor: fault and warning detection, status flags,
// configurable shutdown response with delayed shutdown and restart_wait_period retries.
// Assumes command, telemetry and enable inputs come from logic on clk.
//
// Functional notes
// - Fault sets temperature summary and fault flag, then raises alert.
// - Fault releases only below warning threshold; restart only after release.
// - Warning above fault limit, or disabled: release twenty degrees below limit.
// - Action code 00 ignores the fault and keeps running.
// - Action code 01 runs for the delay, then shuts down if still faulted.
// - Action code 10 shuts down immediately, then follows retry policy.
// - Action code 11 stays off until below warning, then retry policy.
// - Retry code zero latches off after a shutdown.
// - Retry codes one to six: restart_wait_period wait, that many attempts, then latch.
// - Attempts made while still too hot count but stay invisible.
// - Retry code seven retries forever after each restart_wait_period wait.
// - Delay code zero: ten ms delay, restart_wait_period equals rise time.
// - Delay codes one to seven: one to seven ms, restart_wait_period two to four rises.
// - Unsupported register write is refused, flags invalid data, alerts host.
// - Clear in hold mode between thresholds may keep the fault state.
// - Never start while a fault is present, even in ignore mode.
// - Warning sets temperature summary and warning flag, then alerts.
// - Warning register holds five-bit exponent and eleven-bit mantissa.
// - Warning value rounds to whole degrees, zero to 160 supported.
// - Warning threshold of 255 disables the warning function.
// - Fault declared when temperature exceeds the fault limit.
// - Fault limit of 255 disables programmable fault detection.
`timescale 1ns/1ns
`default_nettype none
module ot_supervisor #(
    parameter int CYCLES_PER_MS = ot_resp_pkg::CYCLES_PER_MS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wr_data,
    input wire logic cmd_rd,
    input wire logic clear_faults,
    input wire logic signed [15:0] temp_degc,
    input wire logic signed [15:0] fault_limit_degc,
    input wire logic output_enable,
    input wire logic startup_done,
    input wire logic [7:0] output_rise_time,
    output logic [15:0] rd_data,
    output logic power_stage_on,
    output logic status_temp_summary,
    output logic overtemp_fault_flag,
    output logic overtemp_warning_flag,
    output logic cml_invalid_data,
    output logic alert_req,
    output logic [2:0] restart_count
);
    import ot_resp_pkg::*;

    localparam int DIV_W = $clog2(CYCLES_PER_MS);

    typedef enum logic [2:0] {
        ST_OFF,
        ST_START,
        ST_RUN,
        ST_DELAY,
        ST_SHUT,
        ST_RESTART_WAIT_PERIOD,
        ST_HOLD,
        ST_LATCH
    } state_t;

    typedef struct packed {
        state_t st;
        logic [7:0] action;
        logic [15:0] warn;
        logic ot_active;
        logic [2:0] tries;
        logic [15:0] timer;
        logic [DIV_W-1:0] div;
        logic ms_tick;
        logic [15:0] rd;
        logic pwr_on;
        logic temp_sum;
        logic fault_flag;
        logic warn_flag;
        logic cml_flag;
        logic alert;
    } sup_t;

    sup_t s_r;
    sup_t s_nxt;

    logic signed [15:0] warn_degc;
    logic signed [15:0] wr_degc;
    logic wr_in_range;
    logic fault_cond;
    logic warn_cond;
    logic ot_set_evt;
    logic release_evt;
    logic signed [15:0] release_th;
    action_t act;
    logic [2:0] retry;
    logic [2:0] dly;
    logic [15:0] delay_ms;
    logic [15:0] restart_wait_period_ms;
    logic warn_wr;

    // stored threshold decoded and rounded to whole degrees
    lin11_to_degc u_warn_dec (
        .word(s_r.warn),
        .degc(warn_degc),
        .in_range()
    );

    // Candidate write checked before it may replace the stored threshold
    lin11_to_degc u_wr_dec (
        .word(cmd_wr_data),
        .degc(wr_degc),
        .in_range(wr_in_range)
    );

    always_comb begin
        act = action_t'(s_r.action[ACT_MSB:ACT_LSB]);
        retry = s_r.action[RETRY_MSB:RETRY_LSB];
        dly = s_r.action[DELAY_MSB:DELAY_LSB];
        fault_cond = (fault_limit_degc != DISABLE_DEGC) && (temp_degc > fault_limit_degc);
        warn_cond = (warn_degc != DISABLE_DEGC) && (temp_degc > warn_degc);
        // fixed hysteresis when warning sits above the fault limit
        if (warn_degc > fault_limit_degc) begin
            release_th = 16'(fault_limit_degc - HYST_DEGC);
        end else begin
            release_th = warn_degc;
        end
        ot_set_evt = fault_cond && !s_r.ot_active;
        // release only below the hysteresis threshold
        release_evt = s_r.ot_active && !fault_cond && (temp_degc < release_th);
        delay_ms = (dly == 3'h0) ? DELAY0_MS : 16'(dly);
        if (dly == 3'h0) begin
            restart_wait_period_ms = 16'(output_rise_time);
        end else if (dly < 3'h4) begin
            restart_wait_period_ms = 16'(output_rise_time) << 1;
        end else if (dly < 3'h7) begin
            restart_wait_period_ms = 16'(16'(output_rise_time) * 16'h0003);
        end else begin
            restart_wait_period_ms = 16'(output_rise_time) << 2;
        end
        warn_wr = cmd_wr && (cmd_code == CMD_WARN_LIMIT);
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.ms_tick = 1'b0;
        // Free-running millisecond divider; timers see a one-cycle enable
        if (s_r.div == DIV_W'(CYCLES_PER_MS - 1)) begin
            s_nxt.div = '0;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.div = DIV_W'(s_r.div + 1'b1);
        end
        if (s_r.ms_tick && (s_r.timer != 16'h0000)) begin
            s_nxt.timer = 16'(s_r.timer - 16'h0001);
        end

        // Register writes; every action byte is a defined setting
        if (cmd_wr && (cmd_code == CMD_FAULT_ACTION)) begin
            s_nxt.action = cmd_wr_data[7:0];
        end
        // out-of-range threshold is refused and flagged
        if (warn_wr && wr_in_range) begin
            s_nxt.warn = cmd_wr_data;
        end
        if (cmd_rd) begin
            case (cmd_code)
                CMD_FAULT_ACTION: s_nxt.rd = {8'h00, s_r.action};
                CMD_WARN_LIMIT: s_nxt.rd = s_r.warn;
                default: s_nxt.rd = 16'h0000;
            endcase
        end

        // clear may drop the latched fault without a release event
        if (clear_faults) begin
            s_nxt.ot_active = 1'b0;
            s_nxt.temp_sum = 1'b0;
            s_nxt.fault_flag = 1'b0;
            s_nxt.warn_flag = 1'b0;
            s_nxt.cml_flag = 1'b0;
        end
        if (release_evt) begin
            s_nxt.ot_active = 1'b0;
        end
        // Sets come after clears so a simultaneous event is kept
        if (fault_cond) begin
            s_nxt.ot_active = 1'b1;
        end
        if (fault_cond) begin
            s_nxt.fault_flag = 1'b1;
            s_nxt.temp_sum = 1'b1;
        end
        if (warn_cond) begin
            s_nxt.warn_flag = 1'b1;
            s_nxt.temp_sum = 1'b1;
        end
        if (warn_wr && !wr_in_range) begin
            s_nxt.cml_flag = 1'b1;
        end

        case (s_r.st)
            ST_OFF: begin
                s_nxt.tries = 3'h0;
                // no start-up while a fault is present
                if (output_enable && !fault_cond && !s_r.ot_active) begin
                    s_nxt.st = ST_START;
                end
            end
            ST_START, ST_RUN: begin
                // a good start-up ends the retry sequence
                if ((s_r.st == ST_START) && startup_done) begin
                    s_nxt.st = ST_RUN;
                    s_nxt.tries = 3'h0;
                end
                if (ot_set_evt) begin
                    case (act)
                        ACT_IGNORE: s_nxt.st = s_nxt.st;
                        ACT_DELAYED: begin
                            s_nxt.st = ST_DELAY;
                            s_nxt.timer = delay_ms;
                        end
                        ACT_IMMEDIATE: s_nxt.st = ST_SHUT;
                        ACT_HOLD: s_nxt.st = ST_HOLD;
                        default: s_nxt.st = ST_SHUT;
                    endcase
                end
            end
            ST_DELAY: begin
                // fault gone before the delay ends keeps the output up
                if (!s_r.ot_active) begin
                    s_nxt.st = ST_RUN;
                end else if (s_r.timer == 16'h0000) begin
                    s_nxt.st = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (retry == RETRY_LATCH) begin
                    s_nxt.st = ST_LATCH;
                end else if ((retry == RETRY_FOREVER) || (s_r.tries < retry)) begin
                    s_nxt.st = ST_RESTART_WAIT_PERIOD;
                    s_nxt.timer = restart_wait_period_ms;
                end else begin
                    s_nxt.st = ST_LATCH;
                end
            end
            ST_RESTART_WAIT_PERIOD: begin
                if (s_r.timer == 16'h0000) begin
                    // attempt counts even when it cannot be seen
                    if (retry != RETRY_FOREVER) begin
                        s_nxt.tries = 3'(s_r.tries + 3'h1);
                    end
                    // restart only once the fault has released
                    s_nxt.st = s_r.ot_active ? ST_SHUT : ST_START;
                end
            end
            ST_HOLD: begin
                // only a real release, or output_enable going low, leaves this state
                if (release_evt) begin
                    s_nxt.st = ST_SHUT;
                end
            end
            ST_LATCH: s_nxt.st = ST_LATCH;
            default: s_nxt.st = ST_OFF;
        endcase

        if (!output_enable) begin
            s_nxt.st = ST_OFF;
            s_nxt.tries = 3'h0;
        end
        s_nxt.pwr_on = (s_nxt.st == ST_START) || (s_nxt.st == ST_RUN)
            || (s_nxt.st == ST_DELAY);
        // host notification follows any set flag
        s_nxt.alert = s_nxt.temp_sum || s_nxt.cml_flag;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: ST_OFF, action: FAULT_ACTION_RST, warn: WARN_LIMIT_RST,
                default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rd;
    assign power_stage_on = s_r.pwr_on;
    assign status_temp_summary = s_r.temp_sum;
    assign overtemp_fault_flag = s_r.fault_flag;
    assign overtemp_warning_flag = s_r.warn_flag;
    assign cml_invalid_data = s_r.cml_flag;
    assign alert_req = s_r.alert;
    assign restart_count = s_r.tries;

    sequence s_fault_seen;
        fault_cond && !clear_faults;
    endsequence
    sequence s_delay_held;
        (s_r.st == ST_DELAY)[*2];
    endsequence

    a_fault_status: assert property (@(posedge clk) disable iff (!rstn)
        s_fault_seen |=> overtemp_fault_flag && status_temp_summary ##0 alert_req)
        else $error("fault did not set status and alert");
    a_warn_status: assert property (@(posedge clk) disable iff (!rstn)
        warn_cond |=> overtemp_warning_flag && status_temp_summary && alert_req)
        else $error("warning did not set status and alert");
    a_hyst_release: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.ot_active && !fault_cond && (warn_degc > fault_limit_degc)
        && (temp_degc < 16'(fault_limit_degc - HYST_DEGC))) |=> !s_r.ot_active)
        else $error("fault not released twenty below limit");
    a_ignore_runs: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_RUN) && ot_set_evt && (act == ACT_IGNORE) && output_enable)
        |=> power_stage_on && (s_r.st == ST_RUN))
        else $error("ignore mode interrupted the output");
    a_delay_on: assert property (@(posedge clk) disable iff (!rstn)
        s_delay_held |-> power_stage_on)
        else $error("output dropped during shutdown delay");
    a_immediate_off: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_RUN) && ot_set_evt && (act == ACT_IMMEDIATE))
        |=> !power_stage_on ##1 (s_r.st != ST_START))
        else $error("immediate shutdown not taken");
    a_hold_off: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_HOLD) && !release_evt) |=> !power_stage_on)
        else $error("output on while holding for release");
    a_latch_zero: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_SHUT) && (retry == RETRY_LATCH) && output_enable)
        |=> (s_r.st == ST_LATCH))
        else $error("retry zero did not latch off");
    a_retry_limit: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_SHUT) && (retry != RETRY_FOREVER) && (s_r.tries >= retry)
        && output_enable) |=> (s_r.st == ST_LATCH))
        else $error("retries exceeded without latch off");
    a_hidden_count: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_RESTART_WAIT_PERIOD) && (s_r.timer == 16'h0000) && s_r.ot_active
        && (retry != RETRY_FOREVER) && output_enable)
        |=> (s_r.tries == 3'($past(s_r.tries) + 3'h1)) && !power_stage_on)
        else $error("hidden attempt not counted");
    a_bad_write: assert property (@(posedge clk) disable iff (!rstn)
        (warn_wr && !wr_in_range) |=> cml_invalid_data && alert_req
        && $stable(s_r.warn))
        else $error("invalid threshold write not refused");
    a_no_hot_start: assert property (@(posedge clk) disable iff (!rstn)
        ((s_r.st == ST_OFF) && (fault_cond || s_r.ot_active)) |=> !power_stage_on)
        else $error("started while a fault was present");
    a_count_clear: assert property (@(posedge clk) disable iff (!rstn)
        (!output_enable || ((s_r.st == ST_START) && startup_done))
        |=> (restart_count == 3'h0))
        else $error("attempt counter not cleared");
endmodule : ot_supervisor
`default_nettype wire

// File: tb/host_cmd_model.sv
// Host-side command model driving the supervisor's register port.
// Assumes one clk; requests launch 10 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module host_cmd_model (
    input wire logic clk,
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic [15:0] cmd_wr_data,
    output logic cmd_rd,
    output logic clear_faults
);
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_wr_data = 16'h0000;
        cmd_rd = 1'b0;
        clear_faults = 1'b0;
    end

    // Gap of idle cycles models a slow host
    task automatic access(input logic [7:0] code, input logic wr, input logic [15:0] data,
                          input int gap);
        repeat (gap + 1) @(posedge clk);
        #10;
        cmd_code = code;
        cmd_wr = wr;
        cmd_rd = ~wr;
        cmd_wr_data = data;
        @(posedge clk);
        #10;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        // Released lines invert so stale data never looks valid
        cmd_code = ~code;
        cmd_wr_data = ~data;
    endtask : access

    task automatic clear();
        @(posedge clk);
        #10;
        clear_faults = 1'b1;
        @(posedge clk);
        #10;
        clear_faults = 1'b0;
    endtask : clear
endmodule : host_cmd_model
`default_nettype wire

// File: tb/test_overtemp_fault_warning_response.sv
// Self-checking bench for the overtemperature supervisor.
// Assumes ms timings scaled to 10 cycles per ms; host model drives commands.
`timescale 1ns/1ns
`default_nettype none
module test_overtemp_fault_warning_response;
    import ot_resp_pkg::*;
    localparam int MS = 10;
    logic clk, rstn, output_enable, startup_done;
    logic signed [15:0] temp_degc, fault_limit_degc;
    logic [7:0] output_rise_time, cmd_code;
    logic cmd_wr, cmd_rd, clear_faults;
    logic [15:0] cmd_wr_data, rd_data;
    logic power_stage_on, status_temp_summary, overtemp_fault_flag;
    logic overtemp_warning_flag, cml_invalid_data, alert_req;
    logic [2:0] restart_count;
    int error_cnt, total_checks, seed;
    logic [15:0] v;

    host_cmd_model host (.clk(clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_wr_data(cmd_wr_data), .cmd_rd(cmd_rd), .clear_faults(clear_faults));
    ot_supervisor #(.CYCLES_PER_MS(MS)) dut (.clk(clk), .rstn(rstn), .cmd_code(cmd_code),
        .cmd_wr(cmd_wr), .cmd_wr_data(cmd_wr_data), .cmd_rd(cmd_rd),
        .clear_faults(clear_faults), .temp_degc(temp_degc),
        .fault_limit_degc(fault_limit_degc), .output_enable(output_enable),
        .startup_done(startup_done), .output_rise_time(output_rise_time),
        .rd_data(rd_data), .power_stage_on(power_stage_on),
        .status_temp_summary(status_temp_summary), .overtemp_fault_flag(overtemp_fault_flag),
        .overtemp_warning_flag(overtemp_warning_flag), .cml_invalid_data(cml_invalid_data),
        .alert_req(alert_req), .restart_count(restart_count));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Restart_wait_period length in ms for a delay code and a rise time in ms
    function automatic int restart_wait_period_ms(input logic [2:0] code, input int rise);
        return (code == 3'h0) ? rise : (code < 3'h4) ? 2 * rise
            : (code < 3'h7) ? 3 * rise : 4 * rise;
    endfunction : restart_wait_period_ms

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : cyc

    task automatic wait_pwr(input logic lvl, input int max);
        int n;
        n = 0;
        while (power_stage_on !== lvl && n < max) begin
            cyc(1);
            n++;
        end
    endtask : wait_pwr

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.access(code, 1'b1, data, seed[0]);
    endtask : wr

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        host.access(code, 1'b0, 16'h0000, 0);
        check(rd_data, exp, "read back");
    endtask : rd

    task automatic start_up();
        output_enable = 1'b1;
        cyc(3);
        startup_done = 1'b1;
        cyc(1);
        startup_done = 1'b0;
        cyc(1);
    endtask : start_up

    task automatic restart_clean(input logic [7:0] act);
        output_enable = 1'b0;
        temp_degc = 16'sh0019;
        cyc(2);
        host.clear();
        wr(CMD_FAULT_ACTION, {8'h00, act});
        start_up();
    endtask : restart_clean

    initial begin
        #(20000 * 100);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        seed = 28;
        error_cnt = 0;
        total_checks = 0;
        rstn = 1'b0;
        output_enable = 1'b0;
        startup_done = 1'b0;
        temp_degc = 16'sh0019;
        fault_limit_degc = 16'sh0078;
        output_rise_time = 8'h01;
        repeat (5) @(posedge clk);
        #10;
        rstn = 1'b1;
        rd(CMD_FAULT_ACTION, {8'h00, FAULT_ACTION_RST});
        rd(CMD_WARN_LIMIT, WARN_LIMIT_RST);
        rd(8'h52, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            wr(CMD_FAULT_ACTION, {8'h00, v[7:0]});
            rd(CMD_FAULT_ACTION, {8'h00, v[7:0]});
            v = 16'(unsigned'($random(seed)) % 161);
            wr(CMD_WARN_LIMIT, v);
            rd(CMD_WARN_LIMIT, v);
        end
        check(cml_invalid_data, 1'b0, "valid writes flagged");
        $display("test registers done");
        wr(CMD_WARN_LIMIT, 16'h00c8);
        cyc(1);
        check(cml_invalid_data, 1'b1, "invalid data flag");
        check(alert_req, 1'b1, "invalid data alert");
        rd(CMD_WARN_LIMIT, v);
        host.clear();
        wr(CMD_WARN_LIMIT, 16'h0064);
        temp_degc = 16'sh0069;
        cyc(2);
        check(overtemp_warning_flag, 1'b1, "warning flag");
        check(status_temp_summary, 1'b1, "warning summary");
        check(overtemp_fault_flag, 1'b0, "fault below limit");
        wr(CMD_WARN_LIMIT, 16'h00ff);
        host.clear();
        temp_degc = 16'sh0073;
        cyc(3);
        check(overtemp_warning_flag, 1'b0, "disabled warning");
        wr(CMD_WARN_LIMIT, 16'h0064);
        $display("test flags done");
        restart_clean(8'h80);
        check(power_stage_on, 1'b1, "start");
        temp_degc = fault_limit_degc;
        cyc(3);
        check(overtemp_fault_flag, 1'b0, "fault at limit");
        temp_degc = 16'sh0079;
        cyc(2);
        check(power_stage_on, 1'b0, "immediate off");
        check(overtemp_fault_flag, 1'b1, "fault flag");
        check(status_temp_summary, 1'b1, "fault summary");
        check(alert_req, 1'b1, "fault alert");
        temp_degc = 16'sh0032;
        cyc(6 * MS);
        check(power_stage_on, 1'b0, "latched off");
        $display("test immediate done");
        restart_clean(8'h00);
        temp_degc = 16'sh0082;
        cyc(3);
        check(power_stage_on, 1'b1, "ignore runs on");
        check(overtemp_fault_flag, 1'b1, "ignored fault flagged");
        output_enable = 1'b0;
        cyc(2);
        output_enable = 1'b1;
        cyc(5);
        check(power_stage_on, 1'b0, "no start while hot");
        temp_degc = 16'sh0019;
        wait_pwr(1'b1, 10);
        check(power_stage_on, 1'b1, "start after release");
        $display("test ignore done");
        restart_clean(8'h43);
        temp_degc = 16'sh0082;
        cyc(2 * MS - 2);
        check(power_stage_on, 1'b1, "runs through delay");
        wait_pwr(1'b0, MS + 6);
        check(power_stage_on, 1'b0, "off after delay");
        $display("test delayed done");
        restart_clean(8'h88);
        temp_degc = 16'sh0082;
        cyc(2);
        check(power_stage_on, 1'b0, "restart_wait_period shutdown");
        temp_degc = 16'sh0019;
        wait_pwr(1'b1, 3 * MS);
        check(power_stage_on, 1'b1, "restart after restart_wait_period");
        check(restart_count, 3'h1, "one attempt");
        startup_done = 1'b1;
        cyc(1);
        startup_done = 1'b0;
        cyc(2);
        check(restart_count, 3'h0, "count cleared");
        restart_clean(8'h90);
        temp_degc = 16'sh0082;
        cyc(8 * MS);
        check(power_stage_on, 1'b0, "hot attempts invisible");
        check(restart_count, 3'h2, "hot attempts counted");
        temp_degc = 16'sh0019;
        cyc(6 * MS);
        check(power_stage_on, 1'b0, "latched after attempts");
        $display("test retry done");
        wr(CMD_WARN_LIMIT, 16'h00ff);
        fault_limit_degc = 16'sh0050;
        restart_clean(8'hb8);
        temp_degc = 16'sh0055;
        cyc(2);
        temp_degc = 16'sh0046;
        cyc(5 * MS);
        check(power_stage_on, 1'b0, "inside hysteresis");
        temp_degc = 16'sh0037;
        wait_pwr(1'b1, 3 * MS);
        check(power_stage_on, 1'b1, "retry forever");
        check(restart_count, 3'h0, "endless retry uncounted");
        $display("test hysteresis done");
        restart_clean(8'hcf);
        temp_degc = 16'sh0055;
        cyc(2);
        check(power_stage_on, 1'b0, "hold shutdown");
        temp_degc = 16'sh0046;
        host.clear();
        temp_degc = 16'sh0019;
        cyc(2 * MS);
        check(power_stage_on, 1'b0, "stuck after clear");
        temp_degc = 16'sh0055;
        cyc(2);
        temp_degc = 16'sh0019;
        cyc((restart_wait_period_ms(3'h7, 1) - 1) * MS);
        check(power_stage_on, 1'b0, "long restart_wait_period");
        wait_pwr(1'b1, 2 * MS);
        check(power_stage_on, 1'b1, "restart after hold");
        $display("test hold done");
        finish_test();
    end
endmodule : test_overtemp_fault_warning_response
`default_nettype wire
